// [core/pief_cfg.svh]
// Register map, field positions and reset values of the port input enable and filter select block.
// Assumes inclusion by bare name from the design files under core/.
`ifndef PIEF_CFG_SVH
`define PIEF_CFG_SVH

// ==========================================================
// Register offsets
`define PIEF_ADDR_W          16
`define PIEF_DATA_W          8
`define PIEF_OFS_P4_IN_EN    16'h30bb
`define PIEF_OFS_P5_IN_EN    16'h30bc
`define PIEF_OFS_FLT_SEL0    16'h30ec
`define PIEF_OFS_FLT_DIV     16'h30ef

// ==========================================================
// Reset values
`define PIEF_RST_P4_IN_EN    8'h00
`define PIEF_RST_P5_IN_EN    5'h00
`define PIEF_RST_FLT_SEL0    8'h00
`define PIEF_RST_FLT_DIV     8'h00
`define PIEF_RD_ZERO         8'h00

// ==========================================================
// Field positions
`define PIEF_P5_EN_HI        4
`define PIEF_FSEL_P1_LO      0
`define PIEF_FSEL_P2_LO      2
`define PIEF_FSEL_P3_LO      4
`define PIEF_FSEL_P4_LO      6
`define PIEF_DIV1_LO         0
`define PIEF_DIV1_HI         1
`define PIEF_DIV2_LO         2
`define PIEF_DIV2_HI         4
`define PIEF_DIV3_LO         5
`define PIEF_DIV3_HI         7

// ==========================================================
// Divider geometry
`define PIEF_DIV1_BASE       1
`define PIEF_DIV2_BASE       5
`define PIEF_BUS_CNT_W       12
`define PIEF_LPO_CNT_W       7
`define PIEF_PORT_CNT        4

`endif

// [core/pief_pkg.sv]
// Types shared by the port input enable and filter select block.
// Assumes pief_cfg.svh is available on the include path.
package pief_pkg;

	// ==========================================================
	// Filter clock source of one port
	typedef enum logic [1:0] {
		PIEF_FSEL_BUS  = 2'h0,
		PIEF_FSEL_DIV1 = 2'h1,
		PIEF_FSEL_DIV2 = 2'h2,
		PIEF_FSEL_DIV3 = 2'h3
	} pief_fsel_type;

endpackage : pief_pkg

// [core/pief_flt_if.sv]
// Interface between the top module and one port glitch filter.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Filter channel
interface pief_flt_if #(parameter int WIDTH = 8);
	logic             tick;   // Sample strobe of the selected filter clock
	logic [WIDTH-1:0] raw;    // Synchronised pin levels
	logic [WIDTH-1:0] en;     // Input path enables
	logic [WIDTH-1:0] filt;   // Filtered, enabled levels

	modport ctrl (output tick, output raw, output en, input filt);
	modport flt  (input tick, input raw, input en, output filt);
endinterface : pief_flt_if

`default_nettype wire

// [core/pief_glitch_filter.sv]
// One port glitch filter: a level passes once seen on two consecutive filter ticks.
// Assumes raw is already synchronised to sys_clk_in.
`timescale 1ns/1ps
`default_nettype none

module pief_glitch_filter #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic sys_clk_in,
	input  wire logic rst_n_in,
	// Channel
	pief_flt_if.flt   ch
);

	logic [WIDTH-1:0] last_reg;
	logic [WIDTH-1:0] stable_reg;

	// ==========================================================
	// Sample on each tick; accept only a level seen twice in a row
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_reg   <= '0;
			stable_reg <= '0;
		end else if (ch.tick) begin
			last_reg   <= ch.raw;
			stable_reg <= (ch.raw ~^ last_reg) & ch.raw | ~(ch.raw ~^ last_reg) & stable_reg; // R11
		end
	end

	// ==========================================================
	// Disabled pins read as zero; output straight from a flop
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ch.filt <= '0;
		end else begin
			ch.filt <= stable_reg & ch.en; // R1
		end
	end

endmodule // pief_glitch_filter

`default_nettype wire

// [core/pief_top.sv]
// Port input enables, filter clock selection and filter dividers, with a plain register port.
// Assumes a one-cycle strobe master on sys_clk_in; pins and the low-power oscillator are asynchronous.
`include "pief_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - Fourth port pin input path on when its enable bit is 1, off when 0.
// R2 - Fourth port enable register: eight read/write bits, bit n for pin n, reset 0.
// R3 - Fifth port enable register: read/write bits 4 to 0, 1 enables the pin.
// R4 - Fifth port enable bits 7 to 5 read zero; writes to them do nothing.
// R5 - Filter select bits 7-6 pick fourth port filter clock: bus, set 1, 2, 3.
// R6 - Filter select bits 5-4 pick third port filter clock, same encoding.
// R7 - Filter select bits 3-2 pick second port filter clock, same encoding.
// R8 - A two-bit field picks first port filter clock, 00 bus, 11 set 3.
// R9 - One select register serves four ports; all pins of a port share its clock.
// R10 - First port field is bits 1-0; all fields read/write, reset to bus clock.
// R11 - Filters drop pulses under one filter period, pass pulses over two periods.
// R12 - Divider set 1 gives bus clock over 2, 4, 8 or 16 from bits 1-0.
// R13 - Divider set 2 gives bus clock over 32 to 4096 from bits 4-2.
// R14 - Divider set 3 gives oscillator clock over 1 to 128 from bits 7-5.
module pief_top (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	// Register port
	input  wire logic [15:0] addr_in,
	input  wire logic [7:0]  wr_data_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [7:0]  rd_data_out,
	// Low-power oscillator clock, sampled as a level
	input  wire logic        low_power_osc_clock_in,
	// Port pins
	input  wire logic [7:0]  first_port_pin_in,
	input  wire logic [7:0]  second_port_pin_in,
	input  wire logic [7:0]  third_port_pin_in,
	input  wire logic [7:0]  fourth_port_pin_in,
	input  wire logic [4:0]  fifth_port_pin_in,
	// Input path enables
	output logic      [7:0]  port4_in_en_out,
	output logic      [4:0]  port5_in_en_out,
	// Filtered port levels; fifth port gated by its enables but unfiltered
	output logic      [7:0]  first_port_filt_out,
	output logic      [7:0]  second_port_filt_out,
	output logic      [7:0]  third_port_filt_out,
	output logic      [7:0]  fourth_port_filt_out,
	output logic      [4:0]  fifth_port_in_out
);

	// ==========================================================
	// Declarations
	logic [7:0]                   port4_in_en_bit_reg;
	logic [`PIEF_P5_EN_HI:0]      port5_in_en_bit_reg;
	logic [7:0]                   flt_sel_reg;
	logic [7:0]                   flt_div_reg;
	logic [7:0]                   rd_data_next;
	logic [`PIEF_BUS_CNT_W-1:0]   bus_cnt_reg;
	logic [`PIEF_LPO_CNT_W-1:0]   lpo_cnt_reg;
	logic [2:0]                   lpo_sync_reg;
	logic                         lpo_edge;
	logic                         tick_div1;
	logic                         tick_div2;
	logic                         tick_div3;
	logic [7:0]                   pin_meta_reg [`PIEF_PORT_CNT];
	logic [7:0]                   pin_sync_reg [`PIEF_PORT_CNT];
	logic [4:0]                   p5_meta_reg;
	logic [4:0]                   p5_sync_reg;
	logic [7:0]                   pins_raw [`PIEF_PORT_CNT];
	logic [7:0]                   pins_en [`PIEF_PORT_CNT];
	logic [1:0]                   port_sel [`PIEF_PORT_CNT];

	pief_flt_if #(.WIDTH(8)) flt_ch [`PIEF_PORT_CNT] ();

	// ==========================================================
	// Functions
	// True when the counter low bits selected by the exponent are all ones
	function automatic logic count_wrap(input logic [`PIEF_BUS_CNT_W-1:0] cnt, input int unsigned exp_bits);
		logic [`PIEF_BUS_CNT_W-1:0] mask;
		mask = '0;
		for (int i = 0; i < `PIEF_BUS_CNT_W; i++) begin
			if (i < exp_bits) begin
				mask[i] = 1'b1;
			end
		end
		return &(cnt | ~mask);
	endfunction

	// Picks the sample strobe named by one select field
	function automatic logic pick_tick(input logic [1:0] sel, input logic t1, input logic t2, input logic t3);
		case (pief_pkg::pief_fsel_type'(sel))
			pief_pkg::PIEF_FSEL_BUS:  pick_tick = 1'b1;
			pief_pkg::PIEF_FSEL_DIV1: pick_tick = t1;
			pief_pkg::PIEF_FSEL_DIV2: pick_tick = t2;
			pief_pkg::PIEF_FSEL_DIV3: pick_tick = t3;
			default:                  pick_tick = 1'b1;
		endcase
	endfunction

	// ==========================================================
	// Register writes
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port4_in_en_bit_reg <= `PIEF_RST_P4_IN_EN; // R2
			port5_in_en_bit_reg <= `PIEF_RST_P5_IN_EN;
			flt_sel_reg         <= `PIEF_RST_FLT_SEL0; // R10
			flt_div_reg         <= `PIEF_RST_FLT_DIV;
		end else if (wr_in) begin
			case (addr_in)
				`PIEF_OFS_P4_IN_EN: port4_in_en_bit_reg <= wr_data_in; // R2
				`PIEF_OFS_P5_IN_EN: port5_in_en_bit_reg <= wr_data_in[`PIEF_P5_EN_HI:0]; // R3
				`PIEF_OFS_FLT_SEL0: flt_sel_reg <= wr_data_in; // R10
				`PIEF_OFS_FLT_DIV:  flt_div_reg <= wr_data_in;
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Read mux; unmapped addresses read zero
	always_comb begin
		case (addr_in)
			`PIEF_OFS_P4_IN_EN: rd_data_next = port4_in_en_bit_reg;
			`PIEF_OFS_P5_IN_EN: rd_data_next = {3'h0, port5_in_en_bit_reg}; // R4
			`PIEF_OFS_FLT_SEL0: rd_data_next = flt_sel_reg;
			`PIEF_OFS_FLT_DIV:  rd_data_next = flt_div_reg;
			default:            rd_data_next = `PIEF_RD_ZERO;
		endcase
	end

	// Read data stand in the cycle after the strobe only
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= `PIEF_RD_ZERO;
		end else if (rd_in) begin
			rd_data_out <= rd_data_next;
		end else begin
			rd_data_out <= `PIEF_RD_ZERO;
		end
	end

	// ==========================================================
	// Enable outputs, straight from flops
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port4_in_en_out <= `PIEF_RST_P4_IN_EN;
			port5_in_en_out <= `PIEF_RST_P5_IN_EN;
		end else begin
			port4_in_en_out <= port4_in_en_bit_reg; // R1
			port5_in_en_out <= port5_in_en_bit_reg; // R3
		end
	end

	// ==========================================================
	// Bus clock prescaler for divider sets 1 and 2
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_cnt_reg <= '0;
		end else begin
			bus_cnt_reg <= bus_cnt_reg + 1'b1;
		end
	end

	assign tick_div1 = count_wrap(bus_cnt_reg,
		int'(flt_div_reg[`PIEF_DIV1_HI:`PIEF_DIV1_LO]) + `PIEF_DIV1_BASE); // R12
	assign tick_div2 = count_wrap(bus_cnt_reg,
		int'(flt_div_reg[`PIEF_DIV2_HI:`PIEF_DIV2_LO]) + `PIEF_DIV2_BASE); // R13

	// ==========================================================
	// Oscillator level synchroniser and edge counter for divider set 3
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lpo_sync_reg <= '0;
		end else begin
			lpo_sync_reg <= {lpo_sync_reg[1:0], low_power_osc_clock_in};
		end
	end

	assign lpo_edge = lpo_sync_reg[1] & ~lpo_sync_reg[2];

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lpo_cnt_reg <= '0;
		end else if (lpo_edge) begin
			lpo_cnt_reg <= lpo_cnt_reg + 1'b1;
		end
	end

	assign tick_div3 = lpo_edge & count_wrap({5'h00, lpo_cnt_reg},
		int'(flt_div_reg[`PIEF_DIV3_HI:`PIEF_DIV3_LO])); // R14

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int p = 0; p < `PIEF_PORT_CNT; p++) begin
				pin_meta_reg[p] <= '0;
				pin_sync_reg[p] <= '0;
			end
			p5_meta_reg <= '0;
			p5_sync_reg <= '0;
		end else begin
			pin_meta_reg[0] <= first_port_pin_in;
			pin_meta_reg[1] <= second_port_pin_in;
			pin_meta_reg[2] <= third_port_pin_in;
			pin_meta_reg[3] <= fourth_port_pin_in;
			for (int p = 0; p < `PIEF_PORT_CNT; p++) begin
				pin_sync_reg[p] <= pin_meta_reg[p];
			end
			p5_meta_reg <= fifth_port_pin_in;
			p5_sync_reg <= p5_meta_reg;
		end
	end

	// Fifth port passes unfiltered, gated by its enables
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fifth_port_in_out <= '0;
		end else begin
			fifth_port_in_out <= p5_sync_reg & port5_in_en_bit_reg; // R3
		end
	end

	// ==========================================================
	// Per-port select fields and enables
	assign port_sel[0] = flt_sel_reg[`PIEF_FSEL_P1_LO +: 2]; // R8
	assign port_sel[1] = flt_sel_reg[`PIEF_FSEL_P2_LO +: 2]; // R7
	assign port_sel[2] = flt_sel_reg[`PIEF_FSEL_P3_LO +: 2]; // R6
	assign port_sel[3] = flt_sel_reg[`PIEF_FSEL_P4_LO +: 2]; // R5
	assign pins_en[0]  = 8'hff;
	assign pins_en[1]  = 8'hff;
	assign pins_en[2]  = 8'hff;
	assign pins_en[3]  = port4_in_en_bit_reg; // R1

	// ==========================================================
	// One filter per port; the whole port shares one tick
	for (genvar g = 0; g < `PIEF_PORT_CNT; g++) begin : g_port
		assign flt_ch[g].tick = pick_tick(port_sel[g], tick_div1, tick_div2, tick_div3); // R9
		assign flt_ch[g].raw  = pin_sync_reg[g];
		assign flt_ch[g].en   = pins_en[g];
		assign pins_raw[g]    = flt_ch[g].filt;

		pief_glitch_filter #(
			.WIDTH (8)
		) u_filter (
			.sys_clk_in (sys_clk_in),
			.rst_n_in   (rst_n_in),
			.ch         (flt_ch[g])
		);
	end

	// Filter outputs are flop outputs of the filters
	assign first_port_filt_out  = pins_raw[0];
	assign second_port_filt_out = pins_raw[1];
	assign third_port_filt_out  = pins_raw[2];
	assign fourth_port_filt_out = pins_raw[3];

endmodule // pief_top

`default_nettype wire

// [tb/pief_top_properties.sv]
// Checker of the register port and of the enable gating of pief_top.
// Assumes it is bound into pief_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module pief_top_properties (
	// Clock, reset and register port
	input wire logic        sys_clk_in,
	input wire logic        rst_n_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0]  wr_data_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [7:0]  rd_data_out,
	// Enables and gated levels
	input wire logic [7:0]  port4_in_en_out,
	input wire logic [4:0]  port5_in_en_out,
	input wire logic [7:0]  fourth_port_filt_out,
	input wire logic [4:0]  fifth_port_in_out
);
	// ==========================================================
	// Helpers and defaults
	logic [4:0] wr_low;
	assign wr_low = wr_data_in[4:0]; // Bits the fifth port keeps
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_wr4;
		wr_in && addr_in == 16'h30bb;
	endsequence
	sequence s_wr5;
		wr_in && addr_in == 16'h30bc;
	endsequence

	// ==========================================================
	// Properties
	chk_rd_idle: assert property (!rd_in |=> rd_data_out == 8'h00)
		else $error("read data not idle");
	chk_p4_read: assert property (rd_in && addr_in == 16'h30bb |=> rd_data_out == port4_in_en_out)
		else $error("fourth port enable read wrong");
	chk_p5_read: assert property (rd_in && addr_in == 16'h30bc |=> rd_data_out == {3'h0, port5_in_en_out})
		else $error("fifth port enable read wrong");
	chk_unmapped_read: assert property (rd_in && !(addr_in inside {16'h30bb, 16'h30bc, 16'h30ec, 16'h30ef})
		|=> rd_data_out == 8'h00)
		else $error("unmapped read not zero");
	chk_p4_write: assert property (s_wr4 |=> ##1 port4_in_en_out == $past(wr_data_in, 2))
		else $error("fourth port enable not written");
	chk_p5_write: assert property (s_wr5 |=> ##1 port5_in_en_out == $past(wr_low, 2))
		else $error("fifth port enable not written");
	chk_p4_gate: assert property ((fourth_port_filt_out & ~port4_in_en_out & ~$past(port4_in_en_out)) == 8'h00)
		else $error("disabled fourth port pin not zero");
	chk_p5_gate: assert property ((fifth_port_in_out & ~port5_in_en_out & ~$past(port5_in_en_out)) == 5'h00)
		else $error("disabled fifth port pin not zero");
endmodule // pief_top_properties

bind pief_top pief_top_properties i_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
	.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
	.port4_in_en_out(port4_in_en_out), .port5_in_en_out(port5_in_en_out),
	.fourth_port_filt_out(fourth_port_filt_out), .fifth_port_in_out(fifth_port_in_out));

`default_nettype wire

// [tb/port_input_enable_and_filter_select_test.sv]
// Self-checking bench for pief_top: registers, enables and filters.
// Assumes the core/ files and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module port_input_enable_and_filter_select_test;
	// ==========================================================
	// Signals
	logic        sys_clk_in = 1'b0;
	logic        rst_n_in   = 1'b0;
	logic [15:0] addr_in    = 16'h0000;
	logic [7:0]  wr_data_in = 8'h00;
	logic        wr_in      = 1'b0;
	logic        rd_in      = 1'b0;
	logic [2:0]  oc         = 3'h0;
	logic [7:0]  pin [5]    = '{default: 8'h00};
	logic [7:0]  filt [4];
	logic [7:0]  rd_data_out;
	logic [7:0]  en4;
	logic [4:0]  en5;
	logic [4:0]  f5;
	logic [7:0]  e4;
	logic [7:0]  e5;
	int          fails      = 0;
	int          checked    = 0;
	int          per [4];

	pief_top i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .low_power_osc_clock_in(oc[2]),
		.first_port_pin_in(pin[0]), .second_port_pin_in(pin[1]), .third_port_pin_in(pin[2]),
		.fourth_port_pin_in(pin[3]), .fifth_port_pin_in(pin[4][4:0]), .port4_in_en_out(en4),
		.port5_in_en_out(en5), .first_port_filt_out(filt[0]), .second_port_filt_out(filt[1]),
		.third_port_filt_out(filt[2]), .fourth_port_filt_out(filt[3]), .fifth_port_in_out(f5));

	// ==========================================================
	// Clocks: bus clock 8 ns, oscillator eight bus cycles
	initial forever #4 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) oc <= oc + 3'h1;

	// ==========================================================
	// Compares, bus cycles and expectations
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t register got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t pin level got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge sys_clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge sys_clk_in);
		rd_in <= 1'b0;
		#1 d = rd_data_out;
	endtask
	function automatic logic [7:0] exp_rd(input logic [15:0] a, input logic [7:0] d);
		case (a)
			16'h30bb, 16'h30ec, 16'h30ef: return d;
			16'h30bc: return d & 8'h1f;
			default: return 8'h00;
		endcase
	endfunction
	function automatic int period(input logic [1:0] s, input logic [7:0] d);
		case (s)
			2'h0: return 1;
			2'h1: return 2 << d[1:0];
			2'h2: return 32 << d[4:2];
			default: return 8 << d[7:5];
		endcase
	endfunction
	function automatic logic [7:0] expv(input int k, input logic [7:0] v);
		return (k == 3) ? (v & e4) : v;
	endfunction

	// Step every pin, then glitch each of the four filtered ports one bus cycle short of its filter period, one cycle at bus clock
	task automatic run_cfg(input logic [7:0] fs, input logic [7:0] dv);
		logic [7:0] old [5];
		int lim;
		int k;
		int c;
		e4 = 8'($urandom);
		e5 = 8'($urandom);
		wr(16'h30ec, fs);
		wr(16'h30ef, dv);
		wr(16'h30bb, e4);
		wr(16'h30bc, e5);
		repeat (3) @(posedge sys_clk_in);
		lim = 12;
		for (k = 0; k < 5; k++) begin
			old[k] = pin[k];
			pin[k] <= 8'($urandom);
		end
		for (k = 0; k < 4; k++) begin
			per[k] = period(fs[2*k +: 2], dv);
			lim = (2 * per[k] + 12 > lim) ? 2 * per[k] + 12 : lim;
		end
		for (c = 1; c <= lim; c++) begin
			@(posedge sys_clk_in);
			#1;
			for (k = 0; k < 4; k++) begin
				if (c == per[k] && per[k] > 3) chk_pin(filt[k], expv(k, old[k]));
				if (c == lim) chk_pin(filt[k], expv(k, pin[k]));
			end
		end
		chk_pin({3'h0, f5}, pin[4] & e5 & 8'h1f);
		for (k = 0; k < 4; k++) old[k] = pin[k];
		for (c = 0; c <= lim; c++) begin
			@(posedge sys_clk_in);
			for (k = 0; k < 4; k++) pin[k] <= (c < ((per[k] > 1) ? per[k] - 1 : 1)) ? ~old[k] : old[k];
			#1;
			for (k = 0; k < 4; k++) chk_pin(filt[k], expv(k, old[k]));
		end
		$display("test filter config %h divider %h done", fs, dv);
	endtask

	// Verdict and end of run
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [15:0] amap [5];
		logic [7:0] d;
		logic [7:0] got;
		logic [7:0] rot [4];
		int i;
		amap = '{16'h30bb, 16'h30bc, 16'h30ec, 16'h30ef, 16'h30bd};
		rot = '{8'he4, 8'h93, 8'h4e, 8'h39};
		void'($urandom(32'h13dc));
		repeat (12) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		for (i = 0; i < 5; i++) begin
			rd(amap[i], got);
			chk_reg(got, 8'h00);
		end
		for (i = 0; i < 25; i++) begin
			d = (i < 5) ? 8'hff : 8'($urandom);
			wr(amap[i % 5], d);
			rd(amap[i % 5], got);
			chk_reg(got, exp_rd(amap[i % 5], d));
			if (i % 5 == 0) chk_reg(en4, d);
			if (i % 5 == 1) chk_reg({3'h0, en5}, d & 8'h1f);
		end
		$display("test registers done");
		// Reset in mid-run returns every register and enable to zero
		@(posedge sys_clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		for (i = 0; i < 5; i++) begin
			rd(amap[i], got);
			chk_reg(got, 8'h00);
		end
		chk_reg(en4, 8'h00);
		chk_reg({3'h0, en5}, 8'h00);
		$display("test reset done");
		run_cfg(rot[0], 8'hff);
		for (i = 1; i < 4; i++) run_cfg(rot[i], 8'($urandom) & 8'hef);
		give_verdict();
	end

	// Watchdog well past the longest expected run
	initial begin
		repeat (60000) @(posedge sys_clk_in);
		fails++;
		give_verdict();
	end
endmodule // port_input_enable_and_filter_select_test

`default_nettype wire
